// ===== rtl/chsc_pkg.sv
// Package: constants, register map and types of the configurable fast counter
package chsc_pkg;

	localparam int NCH = 4;

	// Timebase derivation
	localparam int CLK_FREQ_HZ = 200_000_000;
	localparam int TICK_MS     = 1;
	localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / 1000 * TICK_MS;
	localparam int LOSS_MS_DEF = 100;

	// Register map, byte addresses
	localparam logic [11:0] ADDR_GLOBAL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [4:0]  CH_PAGE     = 5'h02;   // paddr[11:7] of channel page 0x100..0x17F
	localparam logic [2:0]  CH_CFG      = 3'h0;
	localparam logic [2:0]  CH_TIMEBASE = 3'h1;
	localparam logic [2:0]  CH_LIMITS   = 3'h2;
	localparam logic [2:0]  CH_PRESETS  = 3'h3;
	localparam logic [2:0]  CH_PRELOAD  = 3'h4;
	localparam logic [2:0]  CH_ACCUM    = 3'h5;
	localparam logic [2:0]  CH_RATE     = 3'h6;
	localparam logic [2:0]  CH_STROBE   = 3'h7;

	// Global control fields
	localparam int GL_ARR_BIT  = 0;
	localparam int GL_POL_LSB  = 1;
	// Status fields
	localparam int ST_LOST_BIT = 0;
	localparam int ST_LERR_BIT = 1;
	localparam int ST_OUT_LSB  = 4;

	// Reset values
	localparam logic [15:0] TIMEBASE_RST = 16'h03E8;  // 1000 ms
	localparam logic [15:0] HI_LIM_RST   = 16'h7FFF;  // +32767
	localparam logic [15:0] LO_LIM_RST   = 16'h0000;
	localparam logic [15:0] ON_PST_RST   = 16'h7FFF;
	localparam logic [15:0] OFF_PST_RST  = 16'h0000;
	localparam logic [15:0] PRELOAD_RST  = 16'h0000;

	typedef enum logic [1:0] {
		CHSC_NORMAL_POLICY           = 2'b00,
		CHSC_FORCE_OUTPUTS_OFF_POLICY = 2'b01,
		CHSC_FREEZE_POLICY           = 2'b10
	} chsc_policy_t;

	typedef enum logic {
		CHSC_LINK_UP   = 1'b0,
		CHSC_LINK_LOST = 1'b1
	} chsc_link_t;

	// Per-channel configuration word, bit 0 = en
	typedef struct packed {
		logic count_neg;   // bit 6
		logic aux_neg;     // bit 5
		logic strobe_sel;  // bit 4
		logic one_shot;    // bit 3
		logic dir_down;    // bit 2
		logic out_en;      // bit 1
		logic en;          // bit 0
	} chsc_cfg_t;

	localparam chsc_cfg_t CFG_RST = '0;

endpackage

// ===== rtl/chsc_top.sv
// Configurable four-channel fast counter unit with APB register access
`timescale 1ns/1ps
`default_nettype none

module chsc_top #(
	parameter int TICK_CYCLES = chsc_pkg::TICK_CYCLES_DEF,
	parameter int LOSS_MS     = chsc_pkg::LOSS_MS_DEF
) (
	input  wire logic        pclk,       // System clock
	input  wire logic        presetn,    // Async reset, active low
	input  wire logic        psel,       // APB select
	input  wire logic        penable,    // APB enable
	input  wire logic        pwrite,     // APB direction
	input  wire logic [11:0] paddr,      // APB byte address
	input  wire logic [31:0] pwdata,     // APB write data
	output logic             pready,     // APB ready
	output logic      [31:0] prdata,     // APB read data
	output logic             pslverr,    // APB error
	input  wire logic [3:0]  count_in,   // Field count inputs
	input  wire logic [3:0]  ctl_in,     // Field strobe or preload inputs
	output logic      [3:0]  count_out   // Comparator outputs
);

	localparam int NIN = 2 * chsc_pkg::NCH;

	// Millisecond tick
	logic [31:0] tick_cnt_reg;
	logic        tick_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
			tick_reg     <= 1'b0;
		end
	end

	// Field input conditioning: three flops, change accepted when stages two and three agree
	logic [NIN-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_d_reg;
	logic [NIN-1:0] rise, fall;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg  <= '0;
			sync2_reg  <= '0;
			sync3_reg  <= '0;
			filt_reg   <= '0;
			filt_d_reg <= '0;
		end else begin
			sync1_reg  <= {ctl_in, count_in};
			sync2_reg  <= sync1_reg;
			sync3_reg  <= sync2_reg;
			filt_reg   <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
			filt_d_reg <= filt_reg;
		end
	end

	assign rise = filt_reg & ~filt_d_reg;
	assign fall = ~filt_reg & filt_d_reg;

	// APB decode; zero wait states, so every access phase completes
	logic       wr_acc, acc_done, ch_hit, glob_hit, stat_hit, mapped;
	logic [1:0] ch_idx;
	logic [2:0] ch_off;
	logic signed [15:0] new_lo, new_hi;
	logic       lim_ok;

	assign pready   = 1'b1;
	assign acc_done = psel & penable;
	assign wr_acc   = acc_done & pwrite;
	assign ch_hit   = (paddr[11:7] == chsc_pkg::CH_PAGE) && (paddr[1:0] == 2'b00);
	assign ch_idx   = paddr[6:5];
	assign ch_off   = paddr[4:2];
	assign glob_hit = (paddr == chsc_pkg::ADDR_GLOBAL);
	assign stat_hit = (paddr == chsc_pkg::ADDR_STATUS);
	assign mapped   = ch_hit | glob_hit | stat_hit;
	assign new_lo   = pwdata[15:0];
	assign new_hi   = pwdata[31:16];
	assign lim_ok   = new_hi > new_lo;

	// Global control
	logic                   arr_reg;   // 1 = quadrature_plus_single_counter
	chsc_pkg::chsc_policy_t pol_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arr_reg <= 1'b0;
			pol_reg <= chsc_pkg::CHSC_NORMAL_POLICY;
		end else if (wr_acc && glob_hit) begin
			arr_reg <= pwdata[chsc_pkg::GL_ARR_BIT];
			pol_reg <= chsc_pkg::chsc_policy_t'(pwdata[chsc_pkg::GL_POL_LSB +: 2]);
		end
	end

	// Host health: any completed bus access counts as the host being alive
	chsc_pkg::chsc_link_t link_reg;
	logic [15:0]          quiet_ms_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_reg     <= chsc_pkg::CHSC_LINK_UP;
			quiet_ms_reg <= 16'h0000;
		end else begin
			case (link_reg)
				chsc_pkg::CHSC_LINK_UP: begin
					if (acc_done) begin
						quiet_ms_reg <= 16'h0000;
					end else if (tick_reg) begin
						if (quiet_ms_reg >= 16'(LOSS_MS - 1)) begin
							link_reg <= chsc_pkg::CHSC_LINK_LOST;
						end
						quiet_ms_reg <= quiet_ms_reg + 16'h0001;
					end
				end
				chsc_pkg::CHSC_LINK_LOST: begin
					if (acc_done) begin
						link_reg     <= chsc_pkg::CHSC_LINK_UP;
						quiet_ms_reg <= 16'h0000;
					end
				end
				default: begin
					link_reg     <= chsc_pkg::CHSC_LINK_UP;
					quiet_ms_reg <= 16'h0000;
				end
			endcase
		end
	end

	// Limit error flag: write one to clear; a new rejection in the same cycle wins
	logic lerr_reg, lim_rej;

	assign lim_rej = wr_acc && ch_hit && (ch_off == chsc_pkg::CH_LIMITS) && !lim_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lerr_reg <= 1'b0;
		end else if (lim_rej) begin
			lerr_reg <= 1'b1;
		end else if (wr_acc && stat_hit && pwdata[chsc_pkg::ST_LERR_BIT]) begin
			lerr_reg <= 1'b0;
		end
	end

	// Channel state
	chsc_pkg::chsc_cfg_t cfg_reg [chsc_pkg::NCH];
	logic        [15:0] tb_reg   [chsc_pkg::NCH];
	logic signed [15:0] hi_reg   [chsc_pkg::NCH];
	logic signed [15:0] lo_reg   [chsc_pkg::NCH];
	logic signed [15:0] on_reg   [chsc_pkg::NCH];
	logic signed [15:0] off_reg  [chsc_pkg::NCH];
	logic signed [15:0] pre_reg  [chsc_pkg::NCH];
	logic signed [16:0] acc_reg  [chsc_pkg::NCH];
	logic signed [15:0] rate_reg [chsc_pkg::NCH];
	logic signed [15:0] stb_reg  [chsc_pkg::NCH];
	logic        [3:0]  cmp_out;

	genvar g;
	generate
		for (g = 0; g < chsc_pkg::NCH; g++) begin : g_ch
			logic               wsel, active, quad, step_up, step_dn, aux_edge, cnt_edge;
			logic               q_valid, q_fwd;
			logic signed [16:0] hi_x, lo_x, acc_next, pre_x, lo_new_x, hi_new_x;
			logic signed [15:0] ivl_reg, ivl_next, p_lo, p_hi;
			logic        [15:0] ms_reg;
			logic               lo_is_on, between, eq_in;

			assign wsel   = wr_acc && ch_hit && (ch_idx == 2'(g));
			// Channels two and three are idle when channel one runs in quadrature
			assign active = cfg_reg[g].en && !(arr_reg && (g == 1 || g == 2));
			assign quad   = arr_reg && (g == 0);

			assign cnt_edge = cfg_reg[g].count_neg ? fall[g] : rise[g];
			assign aux_edge = cfg_reg[g].aux_neg ? fall[chsc_pkg::NCH + g]
			                                     : rise[chsc_pkg::NCH + g];

			// Quadrature: exactly one phase changed; a double change is ignored
			assign q_valid = (filt_reg[0] ^ filt_d_reg[0]) ^ (filt_reg[1] ^ filt_d_reg[1]);
			assign q_fwd   = filt_reg[0] ^ filt_d_reg[1];

			always_comb begin
				if (quad) begin
					step_up = active && q_valid && (q_fwd ^ cfg_reg[g].dir_down);
					step_dn = active && q_valid && !(q_fwd ^ cfg_reg[g].dir_down);
				end else begin
					step_up = active && cnt_edge && !cfg_reg[g].dir_down;
					step_dn = active && cnt_edge && cfg_reg[g].dir_down;
				end
			end

			assign hi_x     = 17'(hi_reg[g]);
			assign lo_x     = 17'(lo_reg[g]);
			assign pre_x    = 17'(pre_reg[g]);
			assign lo_new_x = 17'(new_lo);
			assign hi_new_x = 17'(new_hi);

			// Accumulator may sit one count past either limit
			always_comb begin
				acc_next = acc_reg[g];
				if (step_up) begin
					if (acc_reg[g] > hi_x) begin
						acc_next = cfg_reg[g].one_shot ? acc_reg[g] : lo_x;
					end else begin
						acc_next = acc_reg[g] + 17'sd1;
					end
				end else if (step_dn) begin
					if (acc_reg[g] < lo_x) begin
						acc_next = cfg_reg[g].one_shot ? acc_reg[g] : hi_x;
					end else begin
						acc_next = acc_reg[g] - 17'sd1;
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_reg[g] <= chsc_pkg::CFG_RST;
					tb_reg[g]  <= chsc_pkg::TIMEBASE_RST;
					on_reg[g]  <= chsc_pkg::ON_PST_RST;
					off_reg[g] <= chsc_pkg::OFF_PST_RST;
					pre_reg[g] <= chsc_pkg::PRELOAD_RST;
				end else if (wsel) begin
					case (ch_off)
						chsc_pkg::CH_CFG:      cfg_reg[g] <= chsc_pkg::chsc_cfg_t'(pwdata[6:0]);
						chsc_pkg::CH_TIMEBASE: tb_reg[g]  <= pwdata[15:0];
						chsc_pkg::CH_PRESETS: begin
							on_reg[g]  <= pwdata[15:0];
							off_reg[g] <= pwdata[31:16];
						end
						chsc_pkg::CH_PRELOAD:  pre_reg[g] <= pwdata[15:0];
						default: ;
					endcase
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hi_reg[g] <= chsc_pkg::HI_LIM_RST;
					lo_reg[g] <= chsc_pkg::LO_LIM_RST;
				end else if (wsel && ch_off == chsc_pkg::CH_LIMITS && lim_ok) begin
					hi_reg[g] <= new_hi;
					lo_reg[g] <= new_lo;
				end
			end

			// Host load beats a limit adjust, which beats preload, which beats counting
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					acc_reg[g] <= 17'sd0;
				end else if (wsel && ch_off == chsc_pkg::CH_ACCUM) begin
					acc_reg[g] <= 17'(signed'(pwdata[15:0]));
				end else if (wsel && ch_off == chsc_pkg::CH_LIMITS && lim_ok
				             && (acc_reg[g] > hi_new_x || acc_reg[g] < lo_new_x)) begin
					acc_reg[g] <= lo_new_x;
				end else if (active && !cfg_reg[g].strobe_sel && aux_edge) begin
					acc_reg[g] <= pre_x;
				end else begin
					acc_reg[g] <= acc_next;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stb_reg[g] <= 16'sd0;
				end else if (active && cfg_reg[g].strobe_sel && aux_edge) begin
					stb_reg[g] <= acc_reg[g][15:0];
				end
			end

			// Rate: net counts in the last completed interval, wrapping signed
			always_comb begin
				ivl_next = ivl_reg;
				if (step_up) begin
					ivl_next = ivl_reg + 16'sd1;
				end else if (step_dn) begin
					ivl_next = ivl_reg - 16'sd1;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ms_reg      <= 16'h0000;
					ivl_reg     <= 16'sd0;
					rate_reg[g] <= 16'sd0;
				end else if (tick_reg && (ms_reg + 16'h0001 >= tb_reg[g])) begin
					// A zero timebase behaves as one millisecond
					ms_reg      <= 16'h0000;
					ivl_reg     <= 16'sd0;
					rate_reg[g] <= ivl_next;
				end else begin
					ms_reg  <= tick_reg ? ms_reg + 16'h0001 : ms_reg;
					ivl_reg <= ivl_next;
				end
			end

			// Preset comparator
			assign lo_is_on = on_reg[g] < off_reg[g];
			assign p_lo     = lo_is_on ? on_reg[g] : off_reg[g];
			assign p_hi     = lo_is_on ? off_reg[g] : on_reg[g];
			assign between  = (acc_reg[g] > 17'(p_lo)) && (acc_reg[g] <= 17'(p_hi))
			                  && !(p_lo < lo_reg[g] && p_hi > hi_reg[g]);
			assign eq_in    = (acc_reg[g] == 17'(on_reg[g]))
			                  && (on_reg[g] >= lo_reg[g]) && (on_reg[g] <= hi_reg[g]);

			always_comb begin
				if (!active || !cfg_reg[g].out_en) begin
					cmp_out[g] = 1'b0;
				end else if (on_reg[g] == off_reg[g]) begin
					cmp_out[g] = eq_in;
				end else if (between) begin
					cmp_out[g] = lo_is_on;
				end else begin
					cmp_out[g] = !lo_is_on;
				end
			end
		end
	endgenerate

	// Output policy while the host is absent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_out <= 4'h0;
		end else if (link_reg == chsc_pkg::CHSC_LINK_LOST) begin
			case (pol_reg)
				chsc_pkg::CHSC_FORCE_OUTPUTS_OFF_POLICY: count_out <= 4'h0;
				chsc_pkg::CHSC_FREEZE_POLICY:            count_out <= count_out;
				default:                                 count_out <= cmp_out;
			endcase
		end else begin
			count_out <= cmp_out;
		end
	end

	// Read data is captured in the setup phase so it stands through the access phase
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (glob_hit) begin
			rd_mux[chsc_pkg::GL_ARR_BIT] = arr_reg;
			rd_mux[chsc_pkg::GL_POL_LSB +: 2] = pol_reg;
		end else if (stat_hit) begin
			rd_mux[chsc_pkg::ST_LOST_BIT] = (link_reg == chsc_pkg::CHSC_LINK_LOST);
			rd_mux[chsc_pkg::ST_LERR_BIT] = lerr_reg;
			rd_mux[chsc_pkg::ST_OUT_LSB +: 4] = count_out;
		end else if (ch_hit) begin
			case (ch_off)
				chsc_pkg::CH_CFG:      rd_mux[6:0] = cfg_reg[ch_idx];
				chsc_pkg::CH_TIMEBASE: rd_mux[15:0] = tb_reg[ch_idx];
				chsc_pkg::CH_LIMITS:   rd_mux = {hi_reg[ch_idx], lo_reg[ch_idx]};
				chsc_pkg::CH_PRESETS:  rd_mux = {off_reg[ch_idx], on_reg[ch_idx]};
				chsc_pkg::CH_PRELOAD:  rd_mux = 32'(pre_reg[ch_idx]);
				chsc_pkg::CH_ACCUM:    rd_mux = 32'(acc_reg[ch_idx]);
				chsc_pkg::CH_RATE:     rd_mux = 32'(rate_reg[ch_idx]);
				chsc_pkg::CH_STROBE:   rd_mux = 32'(stb_reg[ch_idx]);
				default:               rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= !mapped
			           || (pwrite && ch_hit && ch_off == chsc_pkg::CH_LIMITS && !lim_ok)
			           || (pwrite && ch_hit && (ch_off == chsc_pkg::CH_RATE
			                                    || ch_off == chsc_pkg::CH_STROBE));
		end
	end

endmodule // chsc_top

`default_nettype wire

// ===== dv/chsc_host_model.sv
// APB host model that issues register transfers to the counter unit
`timescale 1ns/1ps
`default_nettype none
module chsc_host_model (
	input  wire logic        pclk,     // System clock
	output var  logic        psel,     // APB select
	output var  logic        penable,  // APB enable
	output var  logic        pwrite,   // APB direction
	output var  logic [11:0] paddr,    // APB byte address
	output var  logic [31:0] pwdata,   // APB write data
	input  wire logic        pready,   // APB ready
	input  wire logic [31:0] prdata,   // APB read data
	input  wire logic        pslverr   // APB error
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// Request stays put until pready is seen high at a rising edge
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // chsc_host_model
`default_nettype wire

// ===== dv/chsc_properties.sv
// Port-level assertions for the fast counter unit
`timescale 1ns/1ps
`default_nettype none
module chsc_properties (
	input wire logic        pclk,       // System clock
	input wire logic        presetn,    // Async reset, active low
	input wire logic        psel,       // APB select
	input wire logic        penable,    // APB enable
	input wire logic        pwrite,     // APB direction
	input wire logic [11:0] paddr,      // APB byte address
	input wire logic [31:0] pwdata,     // APB write data
	input wire logic        pready,     // APB ready
	input wire logic [31:0] prdata,     // APB read data
	input wire logic        pslverr,    // APB error
	input wire logic [3:0]  count_out   // Comparator outputs
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc_ph;
	logic ch_hit;
	assign acc_ph = psel && penable && pready;
	assign ch_hit = paddr[11:7] == chsc_pkg::CH_PAGE && paddr[1:0] == 2'b00;
	AST_LIM_REJECT: assert property (
		acc_ph && pwrite && ch_hit && paddr[4:2] == chsc_pkg::CH_LIMITS
		&& $signed(pwdata[31:16]) <= $signed(pwdata[15:0]) |-> pslverr)
		else $error("Bad limit pair accepted");
	AST_LIM_ACCEPT: assert property (
		acc_ph && pwrite && ch_hit && paddr[4:2] == chsc_pkg::CH_LIMITS
		&& $signed(pwdata[31:16]) > $signed(pwdata[15:0]) |-> !pslverr)
		else $error("Good limit pair refused");
	AST_RATE_RO: assert property (
		acc_ph && pwrite && ch_hit && paddr[4:2] == chsc_pkg::CH_RATE |-> pslverr)
		else $error("Rate write not refused");
	AST_STROBE_RO: assert property (
		acc_ph && pwrite && ch_hit && paddr[4:2] == chsc_pkg::CH_STROBE |-> pslverr)
		else $error("Strobe write not refused");
	AST_ACC_SEXT: assert property (
		acc_ph && !pwrite && ch_hit && paddr[4:2] == chsc_pkg::CH_ACCUM
		|-> prdata[31:16] == {16{prdata[16]}})
		else $error("Accumulator read not sign extended");
	AST_STATUS_OUT: assert property (
		acc_ph && !pwrite && paddr == chsc_pkg::ADDR_STATUS |-> prdata[7:4] == $past(count_out))
		else $error("Status output bits differ from outputs");
	AST_HOLD: assert property (
		!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
		else $error("Read data changed outside setup");
	AST_UNMAPPED: assert property (
		acc_ph && paddr == 12'h008 |-> pslverr && prdata == 32'h0000_0000)
		else $error("Unmapped access not refused");
endmodule // chsc_properties
bind chsc_top chsc_properties chsc_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .count_out(count_out));
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the fast counter unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int TICK = 20;
	localparam int LOSS = 8;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [3:0]  count_in;
	logic [3:0]  ctl_in;
	logic [3:0]  count_out;
	int          n_fail;
	int          compares;
	chsc_top #(.TICK_CYCLES(TICK), .LOSS_MS(LOSS)) chsc_top_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .count_in(count_in),
		.ctl_in(ctl_in), .count_out(count_out));
	chsc_host_model chsc_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic summarize();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [11:0] ra(input logic [1:0] ch, input logic [2:0] r);
		return {chsc_pkg::CH_PAGE, ch, r, 2'b00};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		logic [31:0] q;
		logic        err;
		chsc_host_model_i.xfer(1'b1, a, d, q, err);
		chk({31'h0, err}, {31'h0, e});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        err;
		chsc_host_model_i.xfer(1'b0, a, 32'h0000_0000, q, err);
		chk(q, x);
	endtask
	// Levels held ten cycles so the three-stage filter always sees them
	task automatic pin(input int ch, input logic v, input logic c);
		@(posedge pclk);
		if (c) ctl_in[ch] <= v;
		else count_in[ch] <= v;
		repeat (9) @(posedge pclk);
	endtask
	task automatic pulse(input int ch);
		pin(ch, 1'b1, 1'b0);
		pin(ch, 1'b0, 1'b0);
	endtask
	task automatic co(input logic e);
		repeat (3) @(posedge pclk);
		chk({31'h0, count_out[0]}, {31'h0, e});
	endtask
	task automatic t_reset();
		rd(ra(0, chsc_pkg::CH_TIMEBASE), 32'h0000_03E8);
		rd(ra(0, chsc_pkg::CH_LIMITS), 32'h7FFF_0000);
		rd(ra(0, chsc_pkg::CH_PRESETS), 32'h0000_7FFF);
		rd(ra(0, chsc_pkg::CH_PRELOAD), 32'h0000_0000);
		rd(ra(0, chsc_pkg::CH_CFG), 32'h0000_0000);
		rd(chsc_pkg::ADDR_GLOBAL, 32'h0000_0000);
	endtask
	task automatic t_count();
		wr(ra(0, chsc_pkg::CH_LIMITS), 32'h0002_0000, 1'b0);
		wr(ra(0, chsc_pkg::CH_CFG), 32'h0000_0001, 1'b0);
		repeat (3) pulse(0);
		rd(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0003);
		pulse(0);
		rd(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0000);
		wr(ra(0, chsc_pkg::CH_CFG), 32'h0000_000D, 1'b0);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0001, 1'b0);
		repeat (3) pulse(0);
		rd(ra(0, chsc_pkg::CH_ACCUM), 32'hFFFF_FFFF);
		wr(ra(0, chsc_pkg::CH_CFG), 32'h0000_0009, 1'b0);
		pulse(0);
		rd(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0000);
	endtask
	task automatic t_limits();
		wr(ra(0, chsc_pkg::CH_LIMITS), 32'h0000_0005, 1'b1);
		rd(ra(0, chsc_pkg::CH_LIMITS), 32'h0002_0000);
		rd(chsc_pkg::ADDR_STATUS, 32'h0000_0002);
		wr(chsc_pkg::ADDR_STATUS, 32'h0000_0002, 1'b0);
		rd(chsc_pkg::ADDR_STATUS, 32'h0000_0000);
		wr(ra(0, chsc_pkg::CH_LIMITS), 32'h0010_0005, 1'b0);
		rd(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0005);
	endtask
	task automatic t_inputs();
		wr(ra(0, chsc_pkg::CH_PRELOAD), 32'h0000_0007, 1'b0);
		pin(0, 1'b1, 1'b1);
		rd(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0007);
		wr(ra(0, chsc_pkg::CH_CFG), 32'h0000_0031, 1'b0);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0009, 1'b0);
		pin(0, 1'b0, 1'b1);
		rd(ra(0, chsc_pkg::CH_STROBE), 32'h0000_0009);
		wr(ra(0, chsc_pkg::CH_CFG), 32'h0000_0041, 1'b0);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0005, 1'b0);
		pin(0, 1'b1, 1'b0);
		rd(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0005);
		pin(0, 1'b0, 1'b0);
		rd(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0006);
		wr(ra(0, chsc_pkg::CH_RATE), 32'h0000_0001, 1'b1);
		wr(ra(0, chsc_pkg::CH_STROBE), 32'h0000_0001, 1'b1);
		rd(12'h008, 32'h0000_0000);
	endtask
	task automatic t_cmp();
		wr(ra(0, chsc_pkg::CH_PRESETS), 32'h000A_0007, 1'b0);
		wr(ra(0, chsc_pkg::CH_CFG), 32'h0000_0001, 1'b0);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0008, 1'b0);
		co(1'b0);
		wr(ra(0, chsc_pkg::CH_CFG), 32'h0000_0003, 1'b0);
		co(1'b1);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_000C, 1'b0);
		co(1'b0);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0006, 1'b0);
		co(1'b0);
		wr(ra(0, chsc_pkg::CH_PRESETS), 32'h0008_0008, 1'b0);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0008, 1'b0);
		co(1'b1);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0009, 1'b0);
		co(1'b0);
		// Presets 0 and 30 both lie outside limits 5..16: upper preset's state
		wr(ra(0, chsc_pkg::CH_PRESETS), 32'h001E_0000, 1'b0);
		co(1'b0);
		wr(ra(0, chsc_pkg::CH_PRESETS), 32'h0008_0008, 1'b0);
	endtask
	task automatic t_quad();
		logic [31:0] q;
		logic        err;
		wr(chsc_pkg::ADDR_GLOBAL, 32'h0000_0001, 1'b0);
		wr(ra(1, chsc_pkg::CH_CFG), 32'h0000_0001, 1'b0);
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0008, 1'b0);
		pin(0, 1'b1, 1'b0);
		pin(1, 1'b1, 1'b0);
		pin(0, 1'b0, 1'b0);
		pin(1, 1'b0, 1'b0);
		chsc_host_model_i.xfer(1'b0, ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0000, q, err);
		chk({31'h0, q == 32'h0000_0008}, 32'h0000_0000);
		rd(ra(1, chsc_pkg::CH_ACCUM), 32'h0000_0000);
		wr(chsc_pkg::ADDR_GLOBAL, 32'h0000_0000, 1'b0);
	endtask
	task automatic t_loss();
		wr(ra(0, chsc_pkg::CH_ACCUM), 32'h0000_0008, 1'b0);
		wr(chsc_pkg::ADDR_GLOBAL, 32'h0000_0002, 1'b0);
		co(1'b1);
		repeat (LOSS * TICK + 60) @(posedge pclk);
		chk({31'h0, count_out[0]}, 32'h0000_0000);
		repeat (100) @(posedge pclk);
		chk({31'h0, count_out[0]}, 32'h0000_0000);
		rd(chsc_pkg::ADDR_GLOBAL, 32'h0000_0002);
		co(1'b1);
		// Freeze: a count taken while the host is away must not reach the pin
		wr(chsc_pkg::ADDR_GLOBAL, 32'h0000_0004, 1'b0);
		repeat (LOSS * TICK + 60) @(posedge pclk);
		pulse(0);
		co(1'b1);
		wr(chsc_pkg::ADDR_GLOBAL, 32'h0000_0000, 1'b0);
		co(1'b0);
	endtask
	// Count period of 20 cycles divides the 100-cycle interval, so any phase sees 5
	task automatic t_rate();
		wr(ra(0, chsc_pkg::CH_LIMITS), 32'h7FFF_0000, 1'b0);
		wr(ra(0, chsc_pkg::CH_CFG), 32'h0000_0001, 1'b0);
		wr(ra(0, chsc_pkg::CH_TIMEBASE), 32'h0000_0005, 1'b0);
		fork
			repeat (16) pulse(0);
			begin
				repeat (250) @(posedge pclk);
				rd(ra(0, chsc_pkg::CH_RATE), 32'h0000_0005);
			end
		join
	endtask
	initial begin
		n_fail = 0;
		compares = 0;
		presetn = 1'b0;
		count_in = 4'h0;
		ctl_in = 4'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_count();
		t_limits();
		t_inputs();
		t_cmp();
		t_quad();
		t_loss();
		t_rate();
		summarize();
	end
	initial begin
		repeat (10000) @(posedge pclk);
		n_fail++;
		summarize();
	end
endmodule // tb_top
`default_nettype wire
